// ==== rtl/irq_controller_timers_port.sv ====
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module irq_controller_timers_port
    import irqc_pkg::*;
(
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_reset,
    // APB slave
    input  wire logic                  i_psel,
    input  wire logic                  i_penable,
    input  wire logic                  i_pwrite,
    input  wire logic [ADDR_W-1:0]     i_paddr,
    input  wire logic [DATA_W-1:0]     i_pwdata,
    output logic      [DATA_W-1:0]     o_prdata,
    output logic                       o_pready,
    output logic                       o_pslverr,
    // Port pins and timer underflow strobes
    input  wire logic [NUM_PINS-1:0]   i_pins,
    input  wire logic [NUM_TIMERS-1:0] i_timer_underflow,
    // Timer reload
    output reload_s                    o_reload_value,
    output logic      [NUM_TIMERS-1:0] o_reload_load,
    // Processor core
    input  wire logic                  i_cpu_awake,
    input  wire logic                  i_irq_ack,
    input  wire logic                  i_reti,
    output logic                       o_irq_req,
    output logic      [VEC_W-1:0]      o_vector_addr,
    output logic                       o_speed_select,
    output logic                       o_sleep_depth_select,
    // Summary interrupt
    output logic                       o_irq
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [NUM_TIMERS-1:0] timer_irq_enable;
    logic [NUM_TIMERS-1:0] timer_irq_flags;
    logic [NUM_PINS-1:0]   pin_irq_enable;
    logic [NUM_PINS-1:0]   pin_irq_flags;
    logic                  global_irq_enable;
    logic                  speed_select;
    logic                  sleep_depth_select;
    logic [REG_W-1:0]      t0_reload_low;
    logic [REG_W-1:0]      t0_reload_high;
    logic [REG_W-1:0]      t1_reload;
    logic [REG_W-1:0]      t2_reload;
    logic [EV_W-1:0]       event_status;
    logic [EV_W-1:0]       event_mask;

    logic [NUM_PINS-1:0]   pin_fall;

    // ------------------------------------------------------------------
    // Pin edge detection
    // ------------------------------------------------------------------
    pin_fall_detect u_pin_fall (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_pins  (i_pins),
        .o_fall  (pin_fall)
    );

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                     input logic [7:0]        idx);
        return a == {2'b00, idx, 2'b00};
    endfunction

    wire setup    = i_psel & ~i_penable;
    wire access   = i_psel & i_penable;
    wire hit_ten  = reg_hit(i_paddr, IDX_TIMER_IRQ_ENABLE);
    wire hit_tfl  = reg_hit(i_paddr, IDX_TIMER_IRQ_FLAGS);
    wire hit_r0l  = reg_hit(i_paddr, IDX_T0_RELOAD_LOW);
    wire hit_r0h  = reg_hit(i_paddr, IDX_T0_RELOAD_HIGH);
    wire hit_r1   = reg_hit(i_paddr, IDX_T1_RELOAD);
    wire hit_r2   = reg_hit(i_paddr, IDX_T2_RELOAD);
    wire hit_pen  = reg_hit(i_paddr, IDX_PIN_IRQ_ENABLE);
    wire hit_pfl  = reg_hit(i_paddr, IDX_PIN_IRQ_FLAGS);
    wire hit_ctl  = reg_hit(i_paddr, IDX_MCU_CONTROL);
    wire hit_evs  = reg_hit(i_paddr, IDX_EVENT_STATUS);
    wire hit_evm  = reg_hit(i_paddr, IDX_EVENT_MASK);
    wire mapped   = hit_ten | hit_tfl | hit_r0l | hit_r0h | hit_r1 |
                    hit_r2 | hit_pen | hit_pfl | hit_ctl | hit_evs |
                    hit_evm;
    wire wr       = access & i_pwrite & mapped;
    wire [REG_W-1:0] wbyte = i_pwdata[REG_W-1:0];

    // Zero wait states; unmapped addresses answer with an error
    assign o_pready  = 1'b1;
    assign o_pslverr = access & ~mapped;

    // Read data selection, reserved bits read as zero
    wire [REG_W-1:0] rd_byte =
        hit_ten ? {5'h00, timer_irq_enable} :
        hit_tfl ? {5'h00, timer_irq_flags} :
        hit_r0l ? t0_reload_low :
        hit_r0h ? t0_reload_high :
        hit_r1  ? t1_reload :
        hit_r2  ? t2_reload :
        hit_pen ? pin_irq_enable :
        hit_pfl ? pin_irq_flags :
        hit_ctl ? {5'h00, global_irq_enable, sleep_depth_select,
                   speed_select} :
        hit_evs ? {4'h0, event_status} :
        hit_evm ? {4'h0, event_mask} : RST_REG8;

    // Read data is sampled in the setup cycle so it stands in the access
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_prdata <= '0;
        end else if (setup) begin
            o_prdata <= {24'h000000, rd_byte};
        end
    end

    // ------------------------------------------------------------------
    // Plain configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            timer_irq_enable <= RST_TIMERS;
            pin_irq_enable   <= RST_REG8;
            t0_reload_low    <= RST_REG8;
            t0_reload_high   <= RST_REG8;
            t1_reload        <= RST_REG8;
            t2_reload        <= RST_REG8;
            event_mask       <= RST_EV;
        end else begin
            if (wr && hit_ten) timer_irq_enable <= wbyte[NUM_TIMERS-1:0];
            if (wr && hit_pen) pin_irq_enable   <= wbyte;
            if (wr && hit_r0l) t0_reload_low    <= wbyte;
            if (wr && hit_r0h) t0_reload_high   <= wbyte;
            if (wr && hit_r1)  t1_reload        <= wbyte;
            if (wr && hit_r2)  t2_reload        <= wbyte;
            if (wr && hit_evm) event_mask       <= wbyte[EV_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Interrupt flags: software can only clear, an event always wins
    // ------------------------------------------------------------------
    wire [NUM_TIMERS-1:0] tfl_keep = (wr && hit_tfl) ?
                                     wbyte[NUM_TIMERS-1:0] : '1;
    wire [NUM_PINS-1:0]   pfl_keep = (wr && hit_pfl) ? wbyte : '1;
    wire [NUM_TIMERS-1:0] next_timer_flags =
        (timer_irq_flags & tfl_keep) | i_timer_underflow;
    wire [NUM_PINS-1:0]   next_pin_flags =
        (pin_irq_flags & pfl_keep) | pin_fall;

    // Flags keep recording while the core sleeps
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            timer_irq_flags <= RST_TIMERS;
            pin_irq_flags   <= RST_REG8;
        end else begin
            timer_irq_flags <= next_timer_flags;
            pin_irq_flags   <= next_pin_flags;
        end
    end

    // ------------------------------------------------------------------
    // Timer reload values and load strobes
    // ------------------------------------------------------------------
    assign o_reload_value.t0 = {t0_reload_high, t0_reload_low};
    assign o_reload_value.t1 = t1_reload;
    assign o_reload_value.t2 = t2_reload;

    // Load lands one cycle after the underflow strobe
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_reload_load <= RST_TIMERS;
        end else begin
            o_reload_load <= i_timer_underflow;
        end
    end

    // ------------------------------------------------------------------
    // Control register with global enable
    // ------------------------------------------------------------------
    // A hardware accept beats a software write in the same cycle, so
    // the handler is never entered with interrupts still open
    wire wr_ctl = wr & hit_ctl;
    wire next_gie = i_irq_ack ? 1'b0 :
                    wr_ctl    ? wbyte[GIE_BIT] :
                    i_reti    ? 1'b1 :
                    global_irq_enable;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            global_irq_enable  <= RST_CTRL[GIE_BIT];
            speed_select       <= RST_CTRL[SPEED_BIT];
            sleep_depth_select <= RST_CTRL[SLEEP_DEPTH_BIT];
        end else begin
            global_irq_enable <= next_gie;
            if (wr_ctl) begin
                speed_select       <= wbyte[SPEED_BIT];
                sleep_depth_select <= wbyte[SLEEP_DEPTH_BIT];
            end
        end
    end

    assign o_speed_select       = speed_select;
    assign o_sleep_depth_select = sleep_depth_select;

    // ------------------------------------------------------------------
    // Level requests and vector selection
    // ------------------------------------------------------------------
    wire pin_pending   = |(next_pin_flags & pin_irq_enable);
    wire timer_pending = |(next_timer_flags & timer_irq_enable);
    // Built from next-state values so the request drops in step with
    // the accept; otherwise the core could take the same level twice
    wire next_req = i_cpu_awake & next_gie &
                    (pin_pending | timer_pending);
    wire [VEC_W-1:0] next_vector =
        pin_pending   ? VEC_PIN :
        timer_pending ? VEC_TIMER : VEC_RESET;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_irq_req     <= 1'b0;
            o_vector_addr <= VEC_RESET;
        end else begin
            o_irq_req     <= next_req;
            o_vector_addr <= next_vector;
        end
    end

    // ------------------------------------------------------------------
    // Summary status: sticky, cleared by reading it
    // ------------------------------------------------------------------
    // Only bits that the read returned are cleared, so a new event in the
    // access cycle survives
    wire [EV_W-1:0] ev_set = {i_timer_underflow, |pin_fall};
    wire [EV_W-1:0] ev_clr = (access && !i_pwrite && hit_evs) ?
                             o_prdata[EV_W-1:0] : RST_EV;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            event_status <= RST_EV;
        end else begin
            event_status <= (event_status & ~ev_clr) | ev_set;
        end
    end

    assign o_irq = |(event_status & event_mask);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_accept;
        i_irq_ack;
    endsequence

    sequence s_return;
        i_reti && !i_irq_ack && !wr_ctl;
    endsequence

    AST_ACCEPT_CLEARS_GIE: assert property (
        s_accept |=> !global_irq_enable && !o_irq_req)
        else $error("global enable survived an accept");

    AST_GIE_BLOCKS: assert property (
        o_irq_req |-> global_irq_enable)
        else $error("request raised with global enable low");

    AST_VECTOR_FIXED: assert property (
        o_irq_req |-> (o_vector_addr == VEC_PIN ||
                       o_vector_addr == VEC_TIMER))
        else $error("request carries an unknown vector");

    AST_VECTOR_REGION: assert property (
        o_vector_addr <= VEC_REGION_END)
        else $error("vector outside the vector region");

    AST_PIN_GATED: assert property (
        o_irq_req && o_vector_addr == VEC_PIN |->
            $past(pin_pending))
        else $error("port vector without an enabled port flag");

    AST_PIN_FLAG_SET: assert property (
        |pin_fall |=> (pin_irq_flags & $past(pin_fall)) == $past(pin_fall))
        else $error("falling edge did not set its flag");

    AST_RELOAD_LOAD: assert property (
        |i_timer_underflow |=> o_reload_load == $past(i_timer_underflow))
        else $error("reload strobe does not follow underflow");

    AST_T0_FLAG: assert property (
        i_timer_underflow[T0_BIT] |=> timer_irq_flags[T0_BIT])
        else $error("timer 0 flag not set");

    AST_T1_FLAG: assert property (
        i_timer_underflow[T1_BIT] |=> timer_irq_flags[T1_BIT])
        else $error("timer 1 flag not set");

    AST_T2_FLAG: assert property (
        i_timer_underflow[T2_BIT] |=> timer_irq_flags[T2_BIT])
        else $error("timer 2 flag not set");

    AST_TIMER_GATED: assert property (
        o_irq_req && o_vector_addr == VEC_TIMER |->
            $past(timer_pending))
        else $error("timer vector without an enabled timer flag");

    AST_ASLEEP_HOLDS: assert property (
        !i_cpu_awake |=> !o_irq_req)
        else $error("request raised while the core sleeps");

    AST_LEVEL_REQUEST: assert property (
        i_cpu_awake && next_gie && (pin_pending || timer_pending)
            |=> o_irq_req)
        else $error("pending enabled level not requested");

    AST_PORT_FIRST: assert property (
        next_req && pin_pending && timer_pending |=>
            o_irq_req && o_vector_addr == VEC_PIN)
        else $error("timer level taken before port level");

    AST_RETURN_SETS_GIE: assert property (
        s_return |=> global_irq_enable)
        else $error("return did not reopen interrupts");

endmodule

`default_nettype wire

// ==== rtl/irqc_pkg.sv ====
package irqc_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W  = 8;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_TIMER_IRQ_ENABLE = 8'h21;
    localparam logic [7:0] IDX_TIMER_IRQ_FLAGS  = 8'h22;
    localparam logic [7:0] IDX_T0_RELOAD_LOW    = 8'h24;
    localparam logic [7:0] IDX_T0_RELOAD_HIGH   = 8'h25;
    localparam logic [7:0] IDX_T1_RELOAD        = 8'h26;
    localparam logic [7:0] IDX_T2_RELOAD        = 8'h28;
    localparam logic [7:0] IDX_PIN_IRQ_ENABLE   = 8'h2b;
    localparam logic [7:0] IDX_PIN_IRQ_FLAGS    = 8'h2c;
    localparam logic [7:0] IDX_MCU_CONTROL      = 8'h34;
    localparam logic [7:0] IDX_EVENT_STATUS     = 8'h40;
    localparam logic [7:0] IDX_EVENT_MASK       = 8'h41;

    // ------------------------------------------------------------------
    // Field layouts and reset values
    // ------------------------------------------------------------------
    localparam int NUM_PINS        = 8;
    localparam int NUM_TIMERS      = 3;
    localparam int GIE_BIT         = 2;
    localparam int SLEEP_DEPTH_BIT = 1;
    localparam int SPEED_BIT       = 0;
    localparam int T0_BIT          = 0;
    localparam int T1_BIT          = 1;
    localparam int T2_BIT          = 2;
    localparam int MCU_CTRL_W      = 3;
    localparam logic [REG_W-1:0]      RST_REG8   = 8'h00;
    localparam logic [MCU_CTRL_W-1:0] RST_CTRL   = 3'h0;
    localparam logic [NUM_TIMERS-1:0] RST_TIMERS = 3'h0;
    localparam logic [NUM_PINS-1:0]   PIN_IDLE   = 8'hff;

    // Own event summary bits
    localparam int EV_W      = 4;
    localparam int EV_PIN    = 0;
    localparam int EV_T0     = 1;
    localparam logic [EV_W-1:0] RST_EV = 4'h0;

    // ------------------------------------------------------------------
    // Program memory vectors
    // ------------------------------------------------------------------
    localparam int VEC_W = 20;
    localparam logic [VEC_W-1:0] VEC_RESET      = 20'h00000;
    localparam logic [VEC_W-1:0] VEC_PIN        = 20'h00002;
    localparam logic [VEC_W-1:0] VEC_TIMER      = 20'h00008;
    localparam logic [VEC_W-1:0] VEC_REGION_END = 20'h0000b;

    // Reload values handed to the timers
    typedef struct packed {
        logic [15:0] t0;
        logic [7:0]  t1;
        logic [7:0]  t2;
    } reload_s;

endpackage

// ==== rtl/pin_fall_detect.sv ====
`timescale 1ns/1ps
`default_nettype none

module pin_fall_detect
    import irqc_pkg::*;
(
    // Clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_reset,
    // Asynchronous port pins and edge pulses
    input  wire logic [NUM_PINS-1:0] i_pins,
    output logic      [NUM_PINS-1:0] o_fall
);

    logic [NUM_PINS-1:0] meta;
    logic [NUM_PINS-1:0] sync;
    logic [NUM_PINS-1:0] prev;

    // ------------------------------------------------------------------
    // Two-flop synchroniser plus history, one slice per pin
    // ------------------------------------------------------------------
    // Idle level is high so a pin held low at release shows up as a falling edge
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            always_ff @(posedge i_clk or posedge i_reset) begin
                if (i_reset) begin
                    meta[g] <= PIN_IDLE[g];
                    sync[g] <= PIN_IDLE[g];
                    prev[g] <= PIN_IDLE[g];
                end else begin
                    meta[g] <= i_pins[g];
                    sync[g] <= meta[g];
                    prev[g] <= sync[g];
                end
            end
            assign o_fall[g] = prev[g] & ~sync[g];
        end
    endgenerate

endmodule

`default_nettype wire

// ==== verification/core_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Core model: takes a request, then returns from it later
// ------------------------------------------------------------------
module core_model
    import irqc_pkg::*;
(
    // Clock
    input  wire logic             i_clk,
    // Request side
    input  wire logic             i_irq_req,
    input  wire logic [VEC_W-1:0] i_vector_addr,
    input  wire logic             i_slow,
    // Answers
    output logic                  o_irq_ack,
    output logic                  o_reti,
    output logic      [VEC_W-1:0] o_taken_vec,
    output var int                o_n_ack,
    output var int                o_n_ret
);
    // A stalled core lets the request stand a few cycles first
    initial begin
        o_irq_ack   = 1'b0;
        o_reti      = 1'b0;
        o_taken_vec = '0;
        o_n_ack     = 0;
        o_n_ret     = 0;
        forever begin
            @(posedge i_clk);
            if (i_irq_req === 1'b1) begin
                repeat (i_slow ? 3 : 0) @(posedge i_clk);
                o_irq_ack <= 1'b1;
                @(posedge i_clk);
                o_taken_vec = i_vector_addr;
                o_irq_ack <= 1'b0;
                o_n_ack++;
                // Handler time leaves software room to clear flags
                repeat (30) @(posedge i_clk);
                o_reti <= 1'b1;
                @(posedge i_clk);
                o_reti <= 1'b0;
                o_n_ret++;
            end
        end
    end
endmodule

`default_nettype wire

// ==== verification/irq_controller_timers_port_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module irq_controller_timers_port_tb_top
    import irqc_pkg::*;
;
    logic clk, rst, psel, penable, pwrite, awake, slow, pready, pslverr;
    logic ack, reti, req, irq, spd, slp;
    logic [ADDR_W-1:0]     paddr;
    logic [DATA_W-1:0]     pwdata, prdata, seed, rv;
    logic [NUM_PINS-1:0]   pins;
    logic [NUM_TIMERS-1:0] und, rload;
    logic [VEC_W-1:0]      vec, tvec;
    logic [1:0]            c;
    reload_s               rval;
    int                    n_ack, n_ret, n_fail, cmp_count, p;
    logic [32:0]           expq[$];

    irq_controller_timers_port irq_controller_timers_port_i (
        .i_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_pins(pins), .i_timer_underflow(und), .o_reload_value(rval),
        .o_reload_load(rload), .i_cpu_awake(awake), .i_irq_ack(ack),
        .i_reti(reti), .o_irq_req(req), .o_vector_addr(vec),
        .o_speed_select(spd), .o_sleep_depth_select(slp), .o_irq(irq));
    core_model core_model_i (
        .i_clk(clk), .i_irq_req(req), .i_vector_addr(vec), .i_slow(slow),
        .o_irq_ack(ack), .o_reti(reti), .o_taken_vec(tvec),
        .o_n_ack(n_ack), .o_n_ret(n_ret));

    // ------------------------------------------------------------------
    // Clock, helpers and scoreboard
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function automatic logic [31:0] lf(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cmp(input logic [32:0] g, input logic [32:0] e);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
        @(posedge clk);
        seed = lf(seed);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {2'b00, i, 2'b00};
        pwdata <= {seed[23:0], d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        apb(1'b1, i, d);
    endtask
    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        expq.push_back({25'h0, e});
        apb(1'b0, i, 8'h00);
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(input int k);
        @(posedge clk);
        und <= 3'(1 << k);
        @(posedge clk);
        und <= 3'h0;
        #1 cmp({30'h0, rload}, 33'(1 << k));
    endtask
    // Waits for the core to take or return, bounded
    task automatic wev;
        int s;
        s = n_ack + n_ret;
        for (int i = 0; i < 100 && n_ack + n_ret == s; i++) @(posedge clk);
        cmp({32'h0, n_ack + n_ret != s}, 33'h1);
    endtask
    task automatic report_and_stop;
        $display("compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Read answers and taken vectors are judged in order of request
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            cmp({pslverr, prdata}, expq.pop_front());
        end
    end
    always @(n_ack) #1 cmp({13'h0, tvec}, expq.pop_front());
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        report_and_stop;
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, slow, und} = '0;
        {paddr, pwdata} = '0;
        rst   = 1'b1;
        awake = 1'b1;
        pins  = PIN_IDLE;
        seed  = 32'he22f;
        n_fail = 0;
        cmp_count = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        #1 cmp({13'h0, vec}, {13'h0, VEC_RESET});
        rd(IDX_TIMER_IRQ_FLAGS, 8'h00);
        rd(IDX_PIN_IRQ_ENABLE, 8'h00);
        rd(IDX_MCU_CONTROL, 8'h00);
        expq.push_back({1'b1, 32'h0});
        apb(1'b0, 8'h30, 8'h00);
        $display("reset test done");
        seed = lf(seed);
        rv   = seed;
        wr(IDX_T0_RELOAD_LOW, rv[7:0]);
        wr(IDX_T0_RELOAD_HIGH, rv[15:8]);
        wr(IDX_T1_RELOAD, rv[23:16]);
        wr(IDX_T2_RELOAD, rv[31:24]);
        #1;
        cmp({1'b0, rval}, {1'b0, rv[15:0], rv[23:16], rv[31:24]});
        wr(IDX_EVENT_MASK, 8'h02);
        pulse(1);
        w(1);
        cmp({32'h0, irq}, 33'h0);
        pulse(0);
        w(1);
        cmp({32'h0, irq}, 33'h1);
        rd(IDX_EVENT_STATUS, 8'h06);
        w(1);
        cmp({32'h0, irq}, 33'h0);
        wr(IDX_TIMER_IRQ_FLAGS, 8'h00);
        $display("summary test done");
        c = seed[1:0];
        wr(IDX_MCU_CONTROL, {5'h0, 1'b1, c});
        #1 cmp({31'h0, slp, spd}, {31'h0, c});
        for (int k = 0; k < 3; k++) begin
            slow = k[0];
            wr(IDX_TIMER_IRQ_ENABLE, 8'(~(1 << k) & 7));
            pulse(k);
            w(4);
            cmp({32'h0, req}, 33'h0);
            rd(IDX_TIMER_IRQ_FLAGS, 8'(1 << k));
            expq.push_back({13'h0, VEC_TIMER});
            wr(IDX_TIMER_IRQ_ENABLE, 8'h07);
            wev;
            rd(IDX_MCU_CONTROL, {6'h0, c});
            wr(IDX_TIMER_IRQ_FLAGS, 8'h00);
            rd(IDX_TIMER_IRQ_FLAGS, 8'h00);
            wev;
            rd(IDX_MCU_CONTROL, {5'h0, 1'b1, c});
        end
        $display("timer test done");
        p = int'(seed[4:2]);
        wr(IDX_PIN_IRQ_ENABLE, 8'(~(1 << p)));
        pins[p] <= 1'b0;
        w(5);
        cmp({32'h0, req}, 33'h0);
        rd(IDX_PIN_IRQ_FLAGS, 8'(1 << p));
        wr(IDX_MCU_CONTROL, {6'h0, c});
        wr(IDX_PIN_IRQ_ENABLE, 8'hff);
        w(3);
        cmp({32'h0, req}, 33'h0);
        awake <= 1'b0;
        wr(IDX_MCU_CONTROL, {5'h0, 1'b1, c});
        pulse(0);
        w(3);
        cmp({32'h0, req}, 33'h0);
        expq.push_back({13'h0, VEC_PIN});
        awake <= 1'b1;
        wev;
        wr(IDX_PIN_IRQ_FLAGS, 8'h00);
        wr(IDX_TIMER_IRQ_FLAGS, 8'h00);
        pins[p] <= 1'b1;
        wev;
        w(10);
        rd(IDX_PIN_IRQ_FLAGS, 8'h00);
        $display("pin test done");
        report_and_stop;
    end
endmodule

`default_nettype wire
